// file: motion_irq_pkg.sv
// Shared constants and types of the motion event interrupt unit.
// Assumes one 25 MHz clock and a sensor core that delivers samples on that clock.
package motion_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets of the internal register port.
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_TAP_THRESHOLD = 6'h1D;
  localparam logic [5:0] ADDR_TAP_MAX_LENGTH = 6'h21;
  localparam logic [5:0] ADDR_TAP_GAP_TIME = 6'h22;
  localparam logic [5:0] ADDR_SECOND_TAP_SPAN = 6'h23;
  localparam logic [5:0] ADDR_ACTIVITY_THRESHOLD = 6'h24;
  localparam logic [5:0] ADDR_INACTIVITY_THRESHOLD = 6'h25;
  localparam logic [5:0] ADDR_INACTIVITY_TIME = 6'h26;
  localparam logic [5:0] ADDR_MOTION_AXIS_CONTROL = 6'h27;
  localparam logic [5:0] ADDR_FALL_THRESHOLD = 6'h28;
  localparam logic [5:0] ADDR_FALL_TIME = 6'h29;
  localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h2E;
  localparam logic [5:0] ADDR_IRQ_ROUTING = 6'h2F;
  localparam logic [5:0] ADDR_IRQ_SOURCE = 6'h30;
  localparam logic [5:0] ADDR_OUTPUT_FORMAT = 6'h31;
  localparam logic [5:0] ADDR_DATA_FIRST = 6'h32;
  localparam logic [5:0] ADDR_DATA_LAST = 6'h37;

  // ----------------------------------------------------------------
  // Field positions and reset value.
  // ----------------------------------------------------------------
  localparam int BIT_DATA_READY = 7;
  localparam int BIT_SINGLE_TAP = 6;
  localparam int BIT_DOUBLE_TAP = 5;
  localparam int BIT_ACTIVITY = 4;
  localparam int BIT_INACTIVITY = 3;
  localparam int BIT_FREE_FALL = 2;
  localparam int BIT_INVERT = 5;
  localparam int ACT_AXIS_LSB = 4;
  localparam int INACT_AXIS_LSB = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int MAG_SHIFT = 4;

  // ----------------------------------------------------------------
  // Timing: base tick and units derived from it.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_TICK_NS = 625000;
  localparam int FAST_TICK_CYCLES = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int GAP_UNIT_NS = 1250000;
  localparam int GAP_UNIT_TICKS = GAP_UNIT_NS / FAST_TICK_NS;
  localparam int FALL_UNIT_NS = 5000000;
  localparam int FALL_UNIT_TICKS = FALL_UNIT_NS / FAST_TICK_NS;
  localparam int INACT_UNIT_NS = 1000000000;
  localparam int INACT_UNIT_TICKS = INACT_UNIT_NS / FAST_TICK_NS;

  // One acceleration sample, three signed axes.
  typedef struct packed {
    logic signed [15:0] z;
    logic signed [15:0] y;
    logic signed [15:0] x;
  } sample_s;

endpackage

// file: dwell_timer.sv
// Dwell timer: fires once when a condition has held longer than a limit.
// Assumes the condition and the tick are on the same clock as this module.
`timescale 1ns/1ns
module dwell_timer
  import motion_irq_pkg::*;
#(
  parameter int UNIT_TICKS = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Timing and condition.
  input wire logic tick_i,
  input wire logic cond_i,
  input wire logic [7:0] limit_i,
  // Result.
  output logic fire_o
);

  localparam int SW = $clog2(UNIT_TICKS + 1);

  if (UNIT_TICKS < 1) begin : g_chk
    $error("dwell_timer needs UNIT_TICKS of at least one");
  end

  logic [SW-1:0] sub, next_sub; // Ticks inside the current unit.
  logic [8:0] units, next_units; // Whole units elapsed, saturating.
  logic done, next_done; // Blocks a second fire in one dwell.
  logic next_fire;

  // Counting restarts whenever the condition drops, so only an unbroken dwell counts.
  always_comb begin
    next_sub = sub;
    next_units = units;
    next_done = done;
    next_fire = 1'b0;
    if (!cond_i) begin
      next_sub = '0;
      next_units = '0;
      next_done = 1'b0;
    end else if (!done && tick_i) begin
      if (sub == SW'(UNIT_TICKS - 1)) begin
        next_sub = '0;
        next_units = units + 9'd1;
      end else begin
        next_sub = sub + SW'(1);
      end
      if (next_units > {1'b0, limit_i}) begin
        next_fire = 1'b1;
        next_done = 1'b1;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub <= '0;
      units <= '0;
      done <= 1'b0;
      fire_o <= 1'b0;
    end else begin
      sub <= next_sub;
      units <= next_units;
      done <= next_done;
      fire_o <= next_fire;
    end
  end

endmodule

// file: tap_sequencer.sv
// Tap sequencer: single and double tap detection from a threshold level.
// Assumes above_i is a level refreshed per sample, and tick_i is the fast tick.
`timescale 1ns/1ns
module tap_sequencer
  import motion_irq_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Inputs.
  input wire logic tick_i,
  input wire logic above_i,
  input wire logic [7:0] max_len_i,
  input wire logic [7:0] gap_i,
  input wire logic [7:0] span_i,
  // One-cycle event pulses.
  output logic single_o,
  output logic double_o
);

  typedef enum logic [2:0] {TAP_IDLE, TAP_FIRST, TAP_GAP, TAP_SPAN, TAP_SECOND, TAP_WAIT_LOW} tap_e;

  tap_e state, next_state;
  logic [9:0] cnt, next_cnt; // Fast ticks in the current phase.
  logic next_single, next_double;

  // A tap is a rise above threshold that falls again before the max length.
  always_comb begin
    next_state = state;
    next_cnt = tick_i ? cnt + 10'd1 : cnt;
    next_single = 1'b0;
    next_double = 1'b0;
    case (state)
      TAP_IDLE: begin
        next_cnt = '0;
        if (above_i && max_len_i != 8'h00) next_state = TAP_FIRST;
      end
      TAP_FIRST: begin
        if (!above_i) begin
          next_single = 1'b1;
          next_cnt = '0;
          next_state = (span_i != 8'h00) ? TAP_GAP : TAP_IDLE;
        end else if (cnt >= {2'b00, max_len_i}) begin
          next_state = TAP_WAIT_LOW;
        end
      end
      TAP_GAP: begin
        // The second tap may not begin before the gap has passed.
        if (cnt >= {1'b0, gap_i, 1'b0}) begin
          next_cnt = '0;
          next_state = TAP_SPAN;
        end
      end
      TAP_SPAN: begin
        if (above_i) begin
          next_cnt = '0;
          next_state = TAP_SECOND;
        end else if (cnt >= {1'b0, span_i, 1'b0}) begin
          next_state = TAP_IDLE;
        end
      end
      TAP_SECOND: begin
        if (!above_i) begin
          next_double = 1'b1;
          next_state = TAP_IDLE;
        end else if (cnt >= {2'b00, max_len_i}) begin
          next_state = TAP_WAIT_LOW;
        end
      end
      TAP_WAIT_LOW: begin
        // A too-long event is not a tap; wait for it to end.
        if (!above_i) next_state = TAP_IDLE;
      end
      default: next_state = TAP_IDLE;
    endcase
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= TAP_IDLE;
      cnt <= '0;
      single_o <= 1'b0;
      double_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      single_o <= next_single;
      double_o <= next_double;
    end
  end

endmodule

// file: motion_event_interrupt_unit.sv
// Interrupt logic of a three-axis motion sensor: event detection, flags, pins.
// Assumes a sensor core and a serial register engine on the same 25 MHz clock.
`timescale 1ns/1ns
module motion_event_interrupt_unit
  import motion_irq_pkg::*;
#(
  parameter int TICK_CYCLES = FAST_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_I,
  // Samples from the sensor core.
  input wire logic SAMPLE_VALID_I,
  input wire sample_s SAMPLE_I,
  // Register port from the serial interface engine.
  input wire logic [5:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Interrupt pins.
  output logic FIRST_IRQ_PIN_O,
  output logic SECOND_IRQ_PIN_O
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------
  logic [7:0] tap_threshold, next_tap_threshold; // Tap level.
  logic [7:0] tap_max_length, next_tap_max_length; // Longest tap, in fast ticks.
  logic [7:0] tap_gap_time, next_tap_gap_time; // Gap before a second tap.
  logic [7:0] second_tap_span, next_second_tap_span; // Window for a second tap.
  logic [7:0] activity_threshold, next_activity_threshold;
  logic [7:0] inactivity_threshold, next_inactivity_threshold;
  logic [7:0] inactivity_time, next_inactivity_time; // Seconds.
  logic [7:0] motion_axis_control, next_motion_axis_control;
  logic [7:0] fall_threshold, next_fall_threshold;
  logic [7:0] fall_time, next_fall_time; // Units of 5 ms.
  logic [7:0] irq_enable, next_irq_enable;
  logic [7:0] irq_routing, next_irq_routing; // One selects the second pin.
  logic [7:0] output_format, next_output_format;

  // Software writes land here; writes to read-only or unmapped offsets are dropped.
  always_comb begin
    next_tap_threshold = tap_threshold;
    next_tap_max_length = tap_max_length;
    next_tap_gap_time = tap_gap_time;
    next_second_tap_span = second_tap_span;
    next_activity_threshold = activity_threshold;
    next_inactivity_threshold = inactivity_threshold;
    next_inactivity_time = inactivity_time;
    next_motion_axis_control = motion_axis_control;
    next_fall_threshold = fall_threshold;
    next_fall_time = fall_time;
    next_irq_enable = irq_enable;
    next_irq_routing = irq_routing;
    next_output_format = output_format;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ADDR_TAP_THRESHOLD: next_tap_threshold = REG_WDATA_I;
        ADDR_TAP_MAX_LENGTH: next_tap_max_length = REG_WDATA_I;
        ADDR_TAP_GAP_TIME: next_tap_gap_time = REG_WDATA_I;
        ADDR_SECOND_TAP_SPAN: next_second_tap_span = REG_WDATA_I;
        ADDR_ACTIVITY_THRESHOLD: next_activity_threshold = REG_WDATA_I;
        ADDR_INACTIVITY_THRESHOLD: next_inactivity_threshold = REG_WDATA_I;
        ADDR_INACTIVITY_TIME: next_inactivity_time = REG_WDATA_I;
        ADDR_MOTION_AXIS_CONTROL: next_motion_axis_control = REG_WDATA_I;
        ADDR_FALL_THRESHOLD: next_fall_threshold = REG_WDATA_I;
        ADDR_FALL_TIME: next_fall_time = REG_WDATA_I;
        ADDR_IRQ_ENABLE: next_irq_enable = REG_WDATA_I;
        ADDR_IRQ_ROUTING: next_irq_routing = REG_WDATA_I;
        ADDR_OUTPUT_FORMAT: next_output_format = REG_WDATA_I;
        default: next_tap_threshold = tap_threshold;
      endcase
    end
  end

  // Registers only; every field clears on reset.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tap_threshold <= REG_RESET;
      tap_max_length <= REG_RESET;
      tap_gap_time <= REG_RESET;
      second_tap_span <= REG_RESET;
      activity_threshold <= REG_RESET;
      inactivity_threshold <= REG_RESET;
      inactivity_time <= REG_RESET;
      motion_axis_control <= REG_RESET;
      fall_threshold <= REG_RESET;
      fall_time <= REG_RESET;
      irq_enable <= REG_RESET;
      irq_routing <= REG_RESET;
      output_format <= REG_RESET;
    end else begin
      tap_threshold <= next_tap_threshold;
      tap_max_length <= next_tap_max_length;
      tap_gap_time <= next_tap_gap_time;
      second_tap_span <= next_second_tap_span;
      activity_threshold <= next_activity_threshold;
      inactivity_threshold <= next_inactivity_threshold;
      inactivity_time <= next_inactivity_time;
      motion_axis_control <= next_motion_axis_control;
      fall_threshold <= next_fall_threshold;
      fall_time <= next_fall_time;
      irq_enable <= next_irq_enable;
      irq_routing <= next_irq_routing;
      output_format <= next_output_format;
    end
  end

  // ----------------------------------------------------------------
  // Fast time base.
  // ----------------------------------------------------------------
  logic [TW-1:0] pre, next_pre; // Prescaler of the 625 us tick.
  logic tick, next_tick; // One-cycle tick pulse.

  // The prescaler is free running so every timer shares one phase.
  always_comb begin
    next_tick = 1'b0;
    next_pre = pre + TW'(1);
    if (pre == TW'(TICK_CYCLES - 1)) begin
      next_pre = '0;
      next_tick = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pre <= '0;
      tick <= 1'b0;
    end else begin
      pre <= next_pre;
      tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // Sample capture and threshold comparison.
  // ----------------------------------------------------------------
  sample_s data, next_data; // Sample shown at the data registers.
  logic [2:0] tap_hi, next_tap_hi; // Per axis: above tap level.
  logic [2:0] act_hi, next_act_hi; // Per axis: above activity level.
  logic [2:0] inact_lo, next_inact_lo; // Per axis: below inactivity level.
  logic [2:0] fall_lo, next_fall_lo; // Per axis: below fall level.
  logic [7:0] mag [3]; // Scaled magnitude per axis.
  logic [15:0] axis_val [3];

  // Scaled, saturated magnitude; comparisons are always dc-coupled.
  function automatic logic [7:0] magnitude(input logic [15:0] v);
    logic [15:0] a;
    logic [15:0] s;
    a = v[15] ? 16'(-v) : v;
    s = a >> MAG_SHIFT;
    magnitude = (|s[15:8]) ? 8'hFF : s[7:0];
  endfunction

  assign axis_val[0] = SAMPLE_I.x;
  assign axis_val[1] = SAMPLE_I.y;
  assign axis_val[2] = SAMPLE_I.z;

  // Each axis is compared against every threshold at once, so all detectors run in parallel.
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign mag[a] = magnitude(axis_val[a]);
    assign next_tap_hi[a] = SAMPLE_VALID_I ? (mag[a] > tap_threshold) : tap_hi[a];
    assign next_act_hi[a] = SAMPLE_VALID_I ? (mag[a] > activity_threshold) : act_hi[a];
    assign next_inact_lo[a] = SAMPLE_VALID_I ? (mag[a] < inactivity_threshold) : inact_lo[a];
    assign next_fall_lo[a] = SAMPLE_VALID_I ? (mag[a] < fall_threshold) : fall_lo[a];
  end

  assign next_data = SAMPLE_VALID_I ? SAMPLE_I : data;

  // Registers only.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      data <= '0;
      tap_hi <= '0;
      act_hi <= '0;
      inact_lo <= '0;
      fall_lo <= '0;
    end else begin
      data <= next_data;
      tap_hi <= next_tap_hi;
      act_hi <= next_act_hi;
      inact_lo <= next_inact_lo;
      fall_lo <= next_fall_lo;
    end
  end

  // ----------------------------------------------------------------
  // Event detectors.
  // ----------------------------------------------------------------
  logic [2:0] act_axes; // Axes taking part in activity.
  logic [2:0] inact_axes; // Axes taking part in inactivity.
  logic act_cond; // Any enabled axis above.
  logic inact_cond; // All enabled axes below.
  logic fall_cond; // All three axes below.
  logic act_seen; // Sample taken last cycle.
  logic single_evt, double_evt, inact_evt, fall_evt;

  assign act_axes = motion_axis_control[ACT_AXIS_LSB +: 3];
  assign inact_axes = motion_axis_control[INACT_AXIS_LSB +: 3];
  assign act_cond = |(act_hi & act_axes);
  // With no axis enabled the inactivity detector stays idle instead of firing at once.
  assign inact_cond = (|inact_axes) && ((inact_lo & inact_axes) == inact_axes);
  assign fall_cond = &fall_lo;

  // Activity is judged on each fresh sample, one cycle after capture.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      act_seen <= 1'b0;
    end else begin
      act_seen <= SAMPLE_VALID_I;
    end
  end

  tap_sequencer u_tap (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(tick),
    .above_i(|tap_hi),
    .max_len_i(tap_max_length),
    .gap_i(tap_gap_time),
    .span_i(second_tap_span),
    .single_o(single_evt),
    .double_o(double_evt)
  );

  // Seconds per unit: 8-bit limit reaches 255 s.
  dwell_timer #(
    .UNIT_TICKS(INACT_UNIT_TICKS)
  ) u_inact (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(tick),
    .cond_i(inact_cond),
    .limit_i(inactivity_time),
    .fire_o(inact_evt)
  );

  // 5 ms per unit: 8-bit limit stays within 1.28 s.
  dwell_timer #(
    .UNIT_TICKS(FALL_UNIT_TICKS)
  ) u_fall (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(tick),
    .cond_i(fall_cond),
    .limit_i(fall_time),
    .fire_o(fall_evt)
  );

  // ----------------------------------------------------------------
  // Latched flags and clearing reads.
  // ----------------------------------------------------------------
  logic [7:0] src, next_src; // Latched event flags.
  logic [7:0] set_vec; // Events arriving this cycle.
  logic [7:0] clr_vec; // Flags a read clears this cycle.

  always_comb begin
    set_vec = '0;
    set_vec[BIT_DATA_READY] = SAMPLE_VALID_I;
    set_vec[BIT_SINGLE_TAP] = single_evt;
    set_vec[BIT_DOUBLE_TAP] = double_evt;
    set_vec[BIT_ACTIVITY] = act_seen && act_cond;
    set_vec[BIT_INACTIVITY] = inact_evt;
    set_vec[BIT_FREE_FALL] = fall_evt;
    clr_vec = '0;
    // Reading the last data byte consumes the sample, so no unread sample remains.
    if (REG_RD_I && REG_ADDR_I == ADDR_DATA_LAST) begin
      clr_vec[BIT_DATA_READY] = 1'b1;
    end
    if (REG_RD_I && REG_ADDR_I == ADDR_IRQ_SOURCE) begin
      clr_vec = 8'h7C;
    end
    // An event in the clearing cycle survives: set wins over clear.
    next_src = set_vec | (src & ~clr_vec);
  end

  // Registers only.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      src <= '0;
    end else begin
      src <= next_src;
    end
  end

  // ----------------------------------------------------------------
  // Register read path.
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [47:0] data_bytes; // Data registers, x low byte first.

  assign data_bytes = {data.z, data.y, data.x};

  // Read data is registered and valid the cycle after the read strobe.
  always_comb begin
    next_rdata = 8'h00;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_TAP_THRESHOLD: next_rdata = tap_threshold;
        ADDR_TAP_MAX_LENGTH: next_rdata = tap_max_length;
        ADDR_TAP_GAP_TIME: next_rdata = tap_gap_time;
        ADDR_SECOND_TAP_SPAN: next_rdata = second_tap_span;
        ADDR_ACTIVITY_THRESHOLD: next_rdata = activity_threshold;
        ADDR_INACTIVITY_THRESHOLD: next_rdata = inactivity_threshold;
        ADDR_INACTIVITY_TIME: next_rdata = inactivity_time;
        ADDR_MOTION_AXIS_CONTROL: next_rdata = motion_axis_control;
        ADDR_FALL_THRESHOLD: next_rdata = fall_threshold;
        ADDR_FALL_TIME: next_rdata = fall_time;
        ADDR_IRQ_ENABLE: next_rdata = irq_enable;
        ADDR_IRQ_ROUTING: next_rdata = irq_routing;
        ADDR_IRQ_SOURCE: next_rdata = src;
        ADDR_OUTPUT_FORMAT: next_rdata = output_format;
        default: begin
          if (REG_ADDR_I >= ADDR_DATA_FIRST && REG_ADDR_I <= ADDR_DATA_LAST) begin
            next_rdata = data_bytes[8 * (REG_ADDR_I - ADDR_DATA_FIRST) +: 8];
          end
        end
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pins.
  // ----------------------------------------------------------------
  logic [7:0] live; // Latched and enabled.
  logic next_first, next_second;

  // Any number of routed events may share a pin; the pins are registered from flags, enable, routing and invert only.
  always_comb begin
    live = src & irq_enable;
    next_first = (|(live & ~irq_routing)) ^ output_format[BIT_INVERT];
    next_second = (|(live & irq_routing)) ^ output_format[BIT_INVERT];
  end

  // Registers only; reset leaves both pins inactive and active high.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FIRST_IRQ_PIN_O <= 1'b0;
      SECOND_IRQ_PIN_O <= 1'b0;
    end else begin
      FIRST_IRQ_PIN_O <= next_first;
      SECOND_IRQ_PIN_O <= next_second;
    end
  end

endmodule

// file: irq_host_model.sv
// Host side of the interrupt pins: turns pin levels into requests.
// Assumes the bench tells it which polarity it programmed.
`timescale 1ns/1ns
module irq_host_model (
  // Pins and programmed polarity.
  input wire logic first_pin_i,
  input wire logic second_pin_i,
  input wire logic active_low_i,
  // Requests seen by the host.
  output logic first_req_o,
  output logic second_req_o
);
  // A low active pin asks for service when it reads 0.
  assign first_req_o = first_pin_i ^ active_low_i;
  assign second_req_o = second_pin_i ^ active_low_i;
endmodule

// file: motion_irq_sva.sv
// Checker of the interrupt unit, seeing only its top ports.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ns
module motion_irq_sva
  import motion_irq_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_I,
  // Samples and register port.
  input wire logic SAMPLE_VALID_I,
  input wire sample_s SAMPLE_I,
  input wire logic [5:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  // Pins.
  input wire logic FIRST_IRQ_PIN_O,
  input wire logic SECOND_IRQ_PIN_O
);
  logic [16:0] cfg; // Enable, routing and invert copies.
  logic [16:0] next_cfg;
  logic [7:0] x_lo; // Low x byte of the newest sample.
  logic [7:0] next_x_lo;
  logic wr;
  // Shadow what the pins depend on, so pins can be tied to writes.
  always_comb begin
    wr = REG_WR_I;
    next_cfg = cfg;
    next_x_lo = SAMPLE_VALID_I ? SAMPLE_I.x[7:0] : x_lo;
    if (wr && REG_ADDR_I == ADDR_IRQ_ENABLE) begin
      next_cfg[16:9] = REG_WDATA_I;
    end
    if (wr && REG_ADDR_I == ADDR_IRQ_ROUTING) begin
      next_cfg[8:1] = REG_WDATA_I;
    end
    if (wr && REG_ADDR_I == ADDR_OUTPUT_FORMAT) begin
      next_cfg[0] = REG_WDATA_I[BIT_INVERT];
    end
  end
  always_ff @(posedge CLK_I) begin
    cfg <= RST_I ? '0 : next_cfg;
    x_lo <= RST_I ? '0 : next_x_lo;
  end
  default clocking cb @(posedge CLK_I); endclocking
  sequence s_held;
    $stable(cfg) [*2];
  endsequence
  sequence s_src;
    REG_RD_I && REG_ADDR_I == ADDR_IRQ_SOURCE;
  endsequence
  property p_rst_pins;
    RST_I |=> !FIRST_IRQ_PIN_O && !SECOND_IRQ_PIN_O;
  endproperty
  property p_first_idle;
    disable iff (RST_I) s_held ##0 (cfg[16:9] & ~cfg[8:1]) == 0 |-> FIRST_IRQ_PIN_O == cfg[0];
  endproperty
  property p_second_idle;
    disable iff (RST_I) s_held ##0 (cfg[16:9] & cfg[8:1]) == 0 |-> SECOND_IRQ_PIN_O == cfg[0];
  endproperty
  property p_ready;
    disable iff (RST_I) SAMPLE_VALID_I ##1 !(REG_RD_I && REG_ADDR_I == ADDR_DATA_LAST) ##1 s_src |=> REG_RDATA_O[7];
  endproperty
  property p_consumed;
    disable iff (RST_I) (REG_RD_I && REG_ADDR_I == ADDR_DATA_LAST && !SAMPLE_VALID_I
      && !$past(SAMPLE_VALID_I)) ##1 s_src |=> !REG_RDATA_O[7];
  endproperty
  property p_byte;
    disable iff (RST_I) REG_RD_I && REG_ADDR_I == ADDR_DATA_FIRST |=> REG_RDATA_O == $past(x_lo);
  endproperty
  property p_low;
    disable iff (RST_I) s_src |=> REG_RDATA_O[1:0] == 2'b00;
  endproperty
  property p_quiet;
    disable iff (RST_I) !REG_RD_I |=> REG_RDATA_O == 8'h00;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins active after reset");
  a_first_idle: assert property (p_first_idle) else $error("first pin without routed event");
  a_second_idle: assert property (p_second_idle) else $error("second pin without routed event");
  a_ready: assert property (p_ready) else $error("new sample flag missing");
  a_consumed: assert property (p_consumed) else $error("new sample flag kept");
  a_byte: assert property (p_byte) else $error("data byte wrong");
  a_low: assert property (p_low) else $error("unused source bits set");
  a_quiet: assert property (p_quiet) else $error("read data without read");
endmodule
bind motion_event_interrupt_unit motion_irq_sva i_sva (.CLK_I, .RST_I, .SAMPLE_VALID_I, .SAMPLE_I,
  .REG_ADDR_I, .REG_WR_I, .REG_WDATA_I, .REG_RD_I, .REG_RDATA_O, .FIRST_IRQ_PIN_O, .SECOND_IRQ_PIN_O);

// file: motion_event_interrupt_unit_tb_top.sv
// Testbench of the interrupt unit through its register port.
// Assumes the unit answers reads one cycle after the strobe.
`timescale 1ns/1ns
module motion_event_interrupt_unit_tb_top;
  import motion_irq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  sample_s smp = '0;
  logic [5:0] adr = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic inv = 1'b0;
  logic [7:0] wd = '0;
  logic [7:0] rdat, got;
  logic p1, p2, q1, q2;
  int num_errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  motion_event_interrupt_unit #(.TICK_CYCLES(4)) i_dut (.CLK_I(clk), .RST_I(rst), .SAMPLE_VALID_I(vld),
    .SAMPLE_I(smp), .REG_ADDR_I(adr), .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RD_I(rd),
    .REG_RDATA_O(rdat), .FIRST_IRQ_PIN_O(p1), .SECOND_IRQ_PIN_O(p2));
  irq_host_model i_host (.first_pin_i(p1), .second_pin_i(p2), .active_low_i(inv),
    .first_req_o(q1), .second_req_o(q2));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Strobes stay up between calls of one kind, so none is set twice at once.
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    rd = 1'b0;
    wr = 1'b1;
    adr = a;
    wd = d;
    @(posedge clk);
    #1;
  endtask
  task automatic reg_rd(input logic [5:0] a);
    wr = 1'b0;
    rd = 1'b1;
    adr = a;
    @(posedge clk);
    #1 got = rdat;
  endtask
  task automatic put(input logic [15:0] x);
    rd = 1'b0;
    wr = 1'b0;
    smp = '{z: 16'h8001, y: 16'h7F02, x: x};
    vld = 1'b1;
    @(posedge clk);
    #1 vld = 1'b0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    #400000 num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    reg_rd(ADDR_IRQ_SOURCE);
    check("source", got, 8'h00);
    check("pins", {6'h00, p2, p1}, 8'h00);
    reg_rd(6'h01);
    check("unmapped", got, 8'h00);
    // Detection and routing are set up before anything is enabled.
    reg_wr(ADDR_ACTIVITY_THRESHOLD, 8'h10);
    reg_wr(ADDR_MOTION_AXIS_CONTROL, 8'h70);
    reg_wr(ADDR_IRQ_ROUTING, 8'h10);
    put(16'h0123);
    reg_rd(ADDR_IRQ_SOURCE);
    check("ready", got & 8'h80, 8'h80);
    check("source", got, 8'h90);
    reg_rd(ADDR_IRQ_SOURCE);
    check("source", got, 8'h80);
    reg_rd(ADDR_IRQ_SOURCE);
    check("source", got, 8'h80);
    check("pins", {6'h00, p2, p1}, 8'h00);
    reg_wr(ADDR_IRQ_ENABLE, 8'h10);
    put(16'hFE00);
    repeat (3) @(posedge clk);
    #1;
    check("pins", {6'h00, p2, p1}, 8'h02);
    reg_wr(ADDR_OUTPUT_FORMAT, 8'h20);
    inv = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("pins", {6'h00, p2, p1}, 8'h01);
    check("request", {6'h00, q2, q1}, 8'h02);
    for (int i = 0; i < 6; i++) begin
      reg_rd(6'(ADDR_DATA_FIRST + i));
      check("data", got, smp[8 * i +: 8]);
    end
    reg_rd(ADDR_IRQ_SOURCE);
    check("source", got, 8'h10);
    reg_rd(ADDR_IRQ_SOURCE);
    check("source", got, 8'h00);
    // Disable, retune and re-enable an event, as a careful host does.
    reg_wr(ADDR_IRQ_ENABLE, 8'h00);
    reg_wr(ADDR_ACTIVITY_THRESHOLD, 8'h20);
    reg_wr(ADDR_IRQ_ENABLE, 8'h10);
    reg_rd(ADDR_ACTIVITY_THRESHOLD);
    check("threshold", got, 8'h20);
    repeat (2) @(posedge clk);
    #1;
    check("pins", {6'h00, p2, p1}, 8'h03);
    // Still samples on every axis must latch a free fall after one time unit.
    reg_wr(ADDR_FALL_THRESHOLD, 8'h40);
    wr = 1'b0;
    smp = '0;
    vld = 1'b1;
    repeat (60) @(posedge clk);
    #1;
    reg_rd(ADDR_IRQ_SOURCE);
    check("fall", got, 8'h84);
    finish_test();
  end
endmodule
